// [design/gpio_mux_pkg.sv]
// ==================================================================
// shared constants of the port block
package gpio_mux_pkg;

    localparam int NUM_PINS = 32;
    localparam int NUM_GROUPS = 8;

    // ==================================================================
    // register word offsets (byte address = 4 * offset)
    localparam logic [4:0] OFS_DIR = 5'h00;
    localparam logic [4:0] OFS_DATA = 5'h04;
    localparam logic [4:0] OFS_SEL_A = 5'h08;
    localparam logic [4:0] OFS_SEL_B = 5'h0c;
    localparam logic [4:0] OFS_SEL_C = 5'h10;
    localparam logic [4:0] OFS_PULLUP = 5'h11;
    localparam logic [4:0] OFS_PORT_CTRL = 5'h12;
    localparam logic [4:0] OFS_BUS_MODE = 5'h13;

    // ==================================================================
    // field positions
    localparam int KEY_INHIBIT_BIT = 7;
    localparam int OD_SEL_BIT = 0;
    localparam int MODE_EXT_BIT = 0;
    localparam int MODE_BUS8_BIT = 1;
    localparam int INPUT_ONLY_PIN = 29;

    // ==================================================================
    // reset values
    localparam logic [31:0] RST_PINS = 32'h0000_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_OD_SEL = 1'b0;

    // ==================================================================
    // pin feature masks, one bit per pin
    localparam logic [31:0] DIR_IMPL = 32'hdfff_ffff;
    localparam logic [31:0] BUS_PIN_MASK = 32'h0000_ffff;
    localparam logic [31:0] BUS8_FREED_MASK = 32'h0000_ff00;
    localparam logic [31:0] OD_PORT_MASK = 32'h0000_ff00;
    localparam logic [31:0] OD_FIXED_MASK = 32'h0003_0000;
    localparam logic [31:0] KEY_MASK = 32'h0f00_0000;
    localparam logic [31:0] MULTI_MASK = 32'h78ff_0000;
    localparam logic [31:0] THIRD_MASK = 32'h007f_0000;
    localparam logic [31:0] PULLUP_IMPL = 32'hdffc_ffff;
    localparam int THIRD_BASE = 16;

endpackage

// [design/pin_ctrl_if.sv]
`timescale 1ns/100ps
// ==================================================================
// settings and sources handed to the pin drivers
interface pin_ctrl_if;
    logic [31:0] dir;
    logic [31:0] latch;
    logic [31:0] sel_a;
    logic [31:0] sel_b;
    logic [7:0] sel_c;
    logic [31:0] bus_pins;
    logic [31:0] od_mask;
    logic [31:0] ext_out;
    logic [31:0] ext_oe;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] p3;

    modport ctrl(output dir, latch, sel_a, sel_b, sel_c, bus_pins,
        od_mask, ext_out, ext_oe, p1, p2, p3);
    modport drive(input dir, latch, sel_a, sel_b, sel_c, bus_pins,
        od_mask, ext_out, ext_oe, p1, p2, p3);
endinterface

// [design/pin_drive.sv]
`timescale 1ns/100ps
// ==================================================================
// per-pin output selection and driver control
module pin_drive
    import gpio_mux_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    pin_ctrl_if.drive cfg,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe
);

    logic [31:0] next_out;
    logic [31:0] next_oe;

    // three-level output choice for one pin
    function automatic logic pick(input int i, input logic a,
        input logic b, input logic c, input logic lat, input logic f1,
        input logic f2, input logic f3);
        logic v;
        v = lat;
        if (a) begin
            if (!MULTI_MASK[i]) begin
                v = f1;
            end else if (THIRD_MASK[i]) begin
                v = b ? (c ? f3 : f1) : f2;
            end else begin
                v = b ? f2 : f1;
            end
        end
        return v;
    endfunction

    // ==================================================================
    // output mux
    always_comb begin
        logic v;
        logic c;
        v = 1'b0;
        c = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
            c = (THIRD_MASK[i]) ? cfg.sel_c[3'(i - THIRD_BASE)] : 1'b0;
            v = pick(i, cfg.sel_a[i], cfg.sel_b[i], c, cfg.latch[i],
                cfg.p1[i], cfg.p2[i], cfg.p3[i]);
            if (cfg.bus_pins[i]) begin
                next_out[i] = cfg.ext_out[i];
                next_oe[i] = cfg.ext_oe[i];
            end else if (cfg.od_mask[i]) begin
                next_out[i] = 1'b0;
                next_oe[i] = cfg.dir[i] & ~v;
            end else begin
                next_out[i] = v;
                next_oe[i] = cfg.dir[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_out <= RST_PINS;
            pin_oe <= RST_PINS;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_od_never_high;
        (pin_out & pin_oe & OD_FIXED_MASK) == 32'h0000_0000;
    endproperty
    a_od_never_high: assert property (p_od_never_high)
        else $error("fixed open-drain pin driven high");

    property p_port_data;
        (cfg.sel_a[3] == 1'b0 && cfg.bus_pins[3] == 1'b0
            && cfg.od_mask[3] == 1'b0) |=> pin_out[3] == $past(cfg.latch[3]);
    endproperty
    a_port_data: assert property (p_port_data)
        else $error("port latch not driven while port mode selected");

    property p_oe_dir;
        (cfg.bus_pins[20] == 1'b0) |=> pin_oe[20] == $past(cfg.dir[20]);
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("output enable differs from direction");

    property p_third_level;
        (cfg.sel_a[18] && cfg.sel_b[18] && cfg.sel_c[2] && !cfg.od_mask[18]
            && !cfg.bus_pins[18]) |=> pin_out[18] == $past(cfg.p3[18]);
    endproperty
    a_third_level: assert property (p_third_level)
        else $error("third peripheral output not selected");

endmodule

// [design/programmable_io_port_mux.sv]
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module programmable_io_port_mux
    import gpio_mux_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_mode,
    input wire logic bus_8bit,
    input wire logic [31:0] ext_bus_out,
    input wire logic [31:0] ext_bus_oe,
    input wire logic [31:0] periph1_out,
    input wire logic [31:0] periph2_out,
    input wire logic [31:0] periph3_out,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pull_up_en,
    output logic [31:0] periph_in,
    output logic key_irq
);

    logic [31:0] dir;
    logic [31:0] latch;
    logic [31:0] sel_a;
    logic [31:0] sel_b;
    logic [7:0] sel_c;
    logic [7:0] pull_grp;
    logic od_sel;
    logic [31:0] pin_meta;
    logic [31:0] pin_sync;
    logic [31:0] bus_pins;
    logic [31:0] key_block;
    logic [31:0] port_rd;
    logic [31:0] next_readdata;
    logic wr_go;
    logic inhibit;

    pin_ctrl_if cfg_if();

    // ==================================================================
    // helpers

    // replace one byte of a pin vector
    function automatic logic [31:0] put_byte(input logic [31:0] vec,
        input logic [1:0] idx, input logic [7:0] val);
        logic [31:0] r;
        r = vec;
        r[8 * idx +: 8] = val;
        return r;
    endfunction

    // bits under keep hold their old value
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [31:0] keep);
        return (old & keep) | (nw & ~keep);
    endfunction

    // word address falls in a four-word pin bank
    function automatic logic in_bank(input logic [4:0] addr,
        input logic [4:0] base);
        return addr[4:2] == base[4:2];
    endfunction

    // ==================================================================
    // pin input synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // key pins idle high: no false key request after reset
            pin_meta <= RST_PINS | KEY_MASK;
            pin_sync <= RST_PINS | KEY_MASK;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // ==================================================================
    // mode decode
    assign inhibit = sel_c[KEY_INHIBIT_BIT];
    assign key_block = inhibit ? KEY_MASK : 32'h0000_0000;
    assign bus_pins = ext_mode ?
        (BUS_PIN_MASK & ~(bus_8bit ? BUS8_FREED_MASK : 32'h0000_0000)) :
        32'h0000_0000;
    assign port_rd = pin_sync & ~key_block;
    assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];

    // ==================================================================
    // avalon handshake: one wait cycle per access
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (in_bank(avs_address, OFS_DIR)) begin
            next_readdata = {24'h000000, dir[8 * avs_address[1:0] +: 8]};
        end else if (in_bank(avs_address, OFS_DATA)) begin
            next_readdata = {24'h000000,
                port_rd[8 * avs_address[1:0] +: 8]};
        end else if (in_bank(avs_address, OFS_SEL_A)) begin
            next_readdata = {24'h000000, sel_a[8 * avs_address[1:0] +: 8]};
        end else if (in_bank(avs_address, OFS_SEL_B)) begin
            next_readdata = {24'h000000, sel_b[8 * avs_address[1:0] +: 8]};
        end else if (avs_address == OFS_SEL_C) begin
            next_readdata = {24'h000000, sel_c};
        end else if (avs_address == OFS_PULLUP) begin
            next_readdata = {24'h000000, pull_grp};
        end else if (avs_address == OFS_PORT_CTRL) begin
            next_readdata = 32'h0000_0000;
            next_readdata[OD_SEL_BIT] = od_sel;
        end else if (avs_address == OFS_BUS_MODE) begin
            next_readdata = 32'h0000_0000;
            next_readdata[MODE_EXT_BIT] = ext_mode;
            next_readdata[MODE_BUS8_BIT] = bus_8bit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_readdata <= RST_PINS;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ==================================================================
    // direction and data latches
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir <= RST_PINS;
        end else if (wr_go && in_bank(avs_address, OFS_DIR)) begin
            dir <= merge(dir, put_byte(dir, avs_address[1:0],
                avs_writedata[7:0]), bus_pins) & DIR_IMPL;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latch <= RST_PINS;
        end else if (wr_go && in_bank(avs_address, OFS_DATA)) begin
            latch <= merge(latch, put_byte(latch, avs_address[1:0],
                avs_writedata[7:0]), bus_pins);
        end
    end

    // ==================================================================
    // function selects
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_a <= RST_PINS;
        end else if (wr_go && in_bank(avs_address, OFS_SEL_A)) begin
            sel_a <= put_byte(sel_a, avs_address[1:0], avs_writedata[7:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_b <= RST_PINS;
        end else if (wr_go && in_bank(avs_address, OFS_SEL_B)) begin
            sel_b <= put_byte(sel_b, avs_address[1:0],
                avs_writedata[7:0]) & MULTI_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_c <= RST_BYTE;
        end else if (wr_go && avs_address == OFS_SEL_C) begin
            sel_c <= avs_writedata[7:0];
        end
    end

    // ==================================================================
    // pull-up groups and port control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pull_grp <= RST_BYTE;
        end else if (wr_go && avs_address == OFS_PULLUP) begin
            pull_grp <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            od_sel <= RST_OD_SEL;
        end else if (wr_go && avs_address == OFS_PORT_CTRL) begin
            od_sel <= avs_writedata[OD_SEL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pull_up_en <= RST_PINS;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pull_up_en[i] <= pull_grp[i / 4] & ~dir[i]
                    & PULLUP_IMPL[i];
            end
        end
    end

    // ==================================================================
    // peripheral input and key request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            periph_in <= RST_PINS;
        end else begin
            periph_in <= pin_sync & ~key_block;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_irq <= 1'b0;
        end else begin
            key_irq <= ~inhibit & (|(~pin_sync & KEY_MASK));
        end
    end

    // ==================================================================
    // pin drivers
    assign cfg_if.dir = dir;
    assign cfg_if.latch = latch;
    assign cfg_if.sel_a = sel_a;
    assign cfg_if.sel_b = sel_b;
    assign cfg_if.sel_c = sel_c;
    assign cfg_if.bus_pins = bus_pins;
    assign cfg_if.od_mask = OD_FIXED_MASK |
        (od_sel ? OD_PORT_MASK : 32'h0000_0000);
    assign cfg_if.ext_out = ext_bus_out;
    assign cfg_if.ext_oe = ext_bus_oe;
    assign cfg_if.p1 = periph1_out;
    assign cfg_if.p2 = periph2_out;
    assign cfg_if.p3 = periph3_out;

    pin_drive u_pin_drive (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cfg(cfg_if.drive),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // ==================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_answer_bound;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer_bound: assert property (p_answer_bound)
        else $error("waitrequest not released after one cycle");

    property p_bus_dir_hold;
        ext_mode && !bus_8bit && $past(ext_mode) && !$past(bus_8bit) |->
            (dir & BUS_PIN_MASK) == ($past(dir) & BUS_PIN_MASK);
    endproperty
    a_bus_dir_hold: assert property (p_bus_dir_hold)
        else $error("bus pin direction changed in bus mode");

    property p_bus_data_hold;
        ext_mode && !bus_8bit && $past(ext_mode) && !$past(bus_8bit) |->
            (latch & BUS_PIN_MASK) == ($past(latch) & BUS_PIN_MASK);
    endproperty
    a_bus_data_hold: assert property (p_bus_data_hold)
        else $error("bus pin data latch changed in bus mode");

    property p_no_dir_bit;
        dir[INPUT_ONLY_PIN] == 1'b0;
    endproperty
    a_no_dir_bit: assert property (p_no_dir_bit)
        else $error("input-only pin holds a direction bit");

    property p_key_inhibit;
        inhibit ##1 inhibit |-> !key_irq;
    endproperty
    a_key_inhibit: assert property (p_key_inhibit)
        else $error("key request raised while inhibited");

    property p_key_raise;
        !inhibit && ((pin_sync & KEY_MASK) != KEY_MASK) |=> key_irq;
    endproperty
    a_key_raise: assert property (p_key_raise)
        else $error("low key input raised no request");

    property p_key_data;
        inhibit |=> (periph_in & KEY_MASK) == 32'h0000_0000;
    endproperty
    a_key_data: assert property (p_key_data)
        else $error("key pin input delivered while inhibited");

    property p_pullup_input;
        ##1 (pull_up_en & $past(dir)) == 32'h0000_0000;
    endproperty
    a_pullup_input: assert property (p_pullup_input)
        else $error("pull-up on an output pin");

    property p_pullup_group;
        (pull_grp[2] && (dir[11:8] == 4'h0)) |=> pull_up_en[11:8] == 4'hf;
    endproperty
    a_pullup_group: assert property (p_pullup_group)
        else $error("pull-up group bit not applied to all four pins");

endmodule

// [tb/pin_partner.sv]
`timescale 1ns/100ps
// ==================================================================
// pin side: own drivers, pull-ups, outside levels
module pin_partner (
    input wire logic core_clk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pull_up_en,
    input wire logic [31:0] ext_drive,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    logic [31:0] last;

    always_ff @(posedge core_clk) begin
        last <= pin_in;
    end

    // floating lines drift every cycle
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (pull_up_en[i])
                pin_in[i] = 1'b1;
            else if (ext_drive[i])
                pin_in[i] = ext_level[i];
            else
                pin_in[i] = ~last[i];
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
// ==================================================================
// bench of the port block
module tb;
    import gpio_mux_pkg::*;
    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic ext_mode, bus_8bit, key_irq;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, ext_bus_out, ext_bus_oe;
    logic [31:0] periph1_out, periph2_out, periph3_out, pin_in, pin_out;
    logic [31:0] pin_oe, pull_up_en, periph_in, ext_drive, ext_level;
    logic [31:0] q, sa, sb, sc, lt;
    logic [63:0] e;
    logic [7:0] dv, lv;
    int failures, n_compared;

    programmable_io_port_mux u_programmable_io_port_mux (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_mode(ext_mode), .bus_8bit(bus_8bit),
        .ext_bus_out(ext_bus_out), .ext_bus_oe(ext_bus_oe),
        .periph1_out(periph1_out), .periph2_out(periph2_out),
        .periph3_out(periph3_out), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .periph_in(periph_in), .key_irq(key_irq));

    pin_partner u_pin_partner (
        .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_in(pin_in));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ==================================================================
    // shared tasks
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40) begin
            failures++;
            end_of_test();
        end
        @(posedge core_clk);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    // {oe, out} expected from selects, latch and direction
    function automatic logic [63:0] exp_pins(input logic [31:0] a, b, c,
        lat, dir, input logic od);
        logic [31:0] o, en;
        logic v, odp;
        for (int i = 0; i < 32; i++) begin
            v = lat[i];
            if (a[i] && THIRD_MASK[i] && b[i])
                v = c[i] ? periph3_out[i] : periph1_out[i];
            else if (a[i] && THIRD_MASK[i])
                v = periph2_out[i];
            else if (a[i] && MULTI_MASK[i])
                v = b[i] ? periph2_out[i] : periph1_out[i];
            else if (a[i])
                v = periph1_out[i];
            odp = OD_FIXED_MASK[i] | (od & OD_PORT_MASK[i]);
            o[i] = odp ? 1'b0 : v;
            en[i] = dir[i] & DIR_IMPL[i] & (odp ? ~v : 1'b1);
        end
        return {en, o};
    endfunction

    function automatic logic [31:0] exp_pu(input logic [7:0] g,
        input logic [31:0] dir);
        logic [31:0] r;
        for (int i = 0; i < 32; i++)
            r[i] = g[i / 4] & ~dir[i] & PULLUP_IMPL[i];
        return r;
    endfunction

    // ==================================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        ext_mode = 1'b0;
        bus_8bit = 1'b0;
        ext_drive = 32'hffff_ffff;
        void'($urandom(32'h3892));
        ext_bus_out = $urandom();
        ext_bus_oe = $urandom();
        periph1_out = $urandom();
        periph2_out = $urandom();
        periph3_out = $urandom();
        ext_level = $urandom();
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(2);
        chk("oe_rst", 32'h0, pin_oe);
        chk("pu_rst", 32'h0, pull_up_en);
        bus(0, 5'h14, 8'h0);
        chk("unmapped", 32'h0, q);
        avs_byteenable <= 4'h0;
        bus(1, OFS_DIR + 5'h2, 8'hff);
        avs_byteenable <= 4'h1;
        bus(0, OFS_DIR + 5'h2, 8'h0);
        chk("dir_be", 32'h0, q);
        for (int k = 0; k < 4; k++) begin
            dv = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom());
            lv = $urandom();
            ext_level <= $urandom();
            bus(1, OFS_DIR, dv);
            bus(1, OFS_DATA, lv);
            settle(5);
            chk("oe0", {24'h0, dv}, pin_oe & 32'hff);
            chk("out0", {24'h0, lv}, pin_out & 32'hff);
            bus(0, OFS_DATA, 8'h0);
            lt = {24'h0, (dv & lv) | (~dv & ext_level[7:0])};
            chk("rd0", lt, q);
        end
        bus(1, OFS_DIR + 5'h3, 8'hff);
        bus(0, OFS_DIR + 5'h3, 8'h0);
        chk("dir3", 32'h0000_00df, q);
        chk("oe29", 32'h0, pin_oe & 32'h2000_0000);
        bus(1, OFS_DIR + 5'h1, 8'hff);
        bus(1, OFS_DIR + 5'h2, 8'hff);
        for (int k = 0; k < 2; k++) begin
            lv = $urandom();
            bus(1, OFS_PORT_CTRL, 8'(k));
            bus(1, OFS_DATA + 5'h1, lv);
            bus(1, OFS_DATA + 5'h2, ~lv);
            settle(2);
            e = exp_pins(0, 0, 0, {8'h0, ~lv, lv, 8'h0}, 32'hffff_ff00, k);
            q = 32'h0003_ff00;
            chk("od_out", e[31:0] & q, pin_out & q);
            chk("od_oe", e[63:32] & q, pin_oe & q);
        end
        bus(1, OFS_PORT_CTRL, 8'h0);
        for (int k = 0; k < 8; k++) begin
            sa = (k == 0) ? 32'h0 : $urandom();
            sb = (k == 0) ? 32'hffff_ffff : $urandom();
            sc = $urandom();
            lt = $urandom();
            periph1_out <= $urandom();
            periph2_out <= $urandom();
            periph3_out <= $urandom();
            for (int p = 2; p < 4; p++) begin
                bus(1, OFS_SEL_A + 5'(p), sa[8*p +: 8]);
                bus(1, OFS_SEL_B + 5'(p), sb[8*p +: 8]);
                bus(1, OFS_DATA + 5'(p), lt[8*p +: 8]);
            end
            bus(1, OFS_SEL_C, {1'b0, sc[6:0]});
            settle(2);
            e = exp_pins(sa, sb, {9'h0, sc[6:0], 16'h0}, lt,
                32'hffff_0000, 0);
            q = 32'hfffc_0000;
            chk("mux_out", e[31:0] & q, pin_out & q);
            q = 32'hffff_0000;
            chk("mux_oe", e[63:32] & q, pin_oe & q);
        end
        bus(0, OFS_SEL_B + 5'h3, 8'h0);
        chk("sel_b3", {24'h0, sb[31:24] & MULTI_MASK[31:24]}, q);
        bus(1, OFS_DIR, 8'h3c);
        bus(1, OFS_DATA, 8'h96);
        bus(1, OFS_PORT_CTRL, 8'h1);
        ext_mode <= 1'b1;
        bus_8bit <= 1'b1;
        bus(1, OFS_DIR, 8'hc3);
        bus(1, OFS_DATA, 8'h69);
        bus(1, OFS_BUS_MODE, 8'h0);
        bus(0, OFS_BUS_MODE, 8'h0);
        chk("mode", 32'h3, q);
        bus(0, OFS_DIR, 8'h0);
        chk("dir_bus", 32'h3c, q);
        chk("bus_out", ext_bus_out & 32'hff, pin_out & 32'hff);
        chk("bus_oe", ext_bus_oe & 32'hff, pin_oe & 32'hff);
        chk("free_out", 32'h0, pin_out & 32'hff00);
        chk("free_oe", {16'h0, ~lv, 8'h0}, pin_oe & 32'hff00);
        ext_mode <= 1'b0;
        bus_8bit <= 1'b0;
        settle(2);
        chk("lat_kept", 32'h96, pin_out & 32'hff);
        chk("dir_kept", 32'h3c, pin_oe & 32'hff);
        bus(1, OFS_PORT_CTRL, 8'h0);
        // 16-bit bus: port 1 belongs to the bus as well
        ext_mode <= 1'b1;
        bus(1, OFS_DIR + 5'h1, 8'h5a);
        bus(1, OFS_DATA + 5'h1, 8'ha5);
        bus(0, OFS_DIR + 5'h1, 8'h0);
        chk("dir16", 32'hff, q);
        ext_mode <= 1'b0;
        settle(2);
        chk("lat16", {16'h0, lv, 8'h0}, pin_out & 32'hff00);
        for (int k = 0; k < 3; k++) begin
            lt = (k == 0) ? 32'h0 : $urandom();
            dv = (k == 0) ? 8'hff : 8'($urandom());
            for (int p = 0; p < 4; p++)
                bus(1, OFS_DIR + 5'(p), lt[8*p +: 8]);
            bus(1, OFS_PULLUP, dv);
            settle(2);
            chk("pull_up", exp_pu(dv, lt), pull_up_en);
        end
        bus(1, OFS_PULLUP, 8'h0);
        bus(1, OFS_DIR + 5'h3, 8'h0);
        bus(1, OFS_SEL_A + 5'h3, 8'h0);
        bus(1, OFS_SEL_C, 8'h0);
        ext_level <= 32'h0;
        settle(5);
        chk("irq_on", 32'h1, {31'h0, key_irq});
        bus(1, OFS_SEL_C, 8'h80);
        settle(5);
        chk("irq_off", 32'h0, {31'h0, key_irq});
        ext_level <= 32'hffff_ffff;
        settle(5);
        bus(0, OFS_DATA + 5'h3, 8'h0);
        chk("key_rd", 32'hf0, q);
        chk("key_in", 32'h0, periph_in & KEY_MASK);
        end_of_test();
    end
endmodule
